// ### hw/tsr_params.svh
// Constants for the thermal sensor register block
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH
`define TSR_CMD_RSVD      8'h00
`define TSR_CMD_T1        8'h01
`define TSR_CMD_STAT1     8'h02
`define TSR_CMD_CFG_RD    8'h03
`define TSR_CMD_RATE_RD   8'h04
`define TSR_CMD_HI1_RD    8'h07
`define TSR_CMD_LO1_RD    8'h08
`define TSR_CMD_CFG_WR    8'h09
`define TSR_CMD_RATE_WR   8'h0A
`define TSR_CMD_HI1_WR    8'h0D
`define TSR_CMD_LO1_WR    8'h0E
`define TSR_CMD_ONESHOT   8'h0F
`define TSR_CMD_OFS1      8'h11
`define TSR_CMD_STAT2     8'h23
`define TSR_CMD_T2        8'h30
`define TSR_CMD_HI2       8'h31
`define TSR_CMD_LO2       8'h32
`define TSR_CMD_RSVD33    8'h33
`define TSR_CMD_OFS2      8'h34
`define TSR_CMD_REV       8'hFF
`define TSR_RST_CFG       8'h00
`define TSR_RST_RATE      8'h07
`define TSR_RST_HI        8'h55
`define TSR_RST_LO        8'h00
`define TSR_RST_ZERO      8'h00
`define TSR_ARA_ADDR      7'h0C
`define TSR_CFG_MASK_BIT  7
`define TSR_CFG_STBY_BIT  6
`define TSR_RATE_AVG_BIT  7
`define TSR_ST_BUSY_BIT   7
`define TSR_ST_HIGH_BIT   4
`define TSR_ST_LOW_BIT    3
`define TSR_ST_OPEN_BIT   2
`define TSR_ST_ALERT_BIT  0
`define TSR_RATE_CONT     4'hA
`define TSR_RATE_MAX      4'h9
`define TSR_TEMP_MAX      8'h7F
`define TSR_CLK_MHZ       250
`define TSR_FASTEST_US    31250
`endif

// ### hw/tsr_pkg.sv
// Types for the thermal sensor register block
package tsr_pkg;
  typedef enum logic [1:0] {
    TSR_IDLE = 2'b00,
    TSR_CONV = 2'b01,
    TSR_DONE = 2'b11
  } tsr_conv_state_t;
  typedef enum logic [1:0] {
    TSR_TXN_WRITE = 2'b00,
    TSR_TXN_READ  = 2'b01,
    TSR_TXN_SEND  = 2'b10,
    TSR_TXN_RECV  = 2'b11
  } tsr_txn_t;
endpackage

// ### hw/tsr_regs.sv
// Register, conversion and alert logic of a two-core SMBus thermal sensor
// Contract
// - Alert response read returns own seven-bit address in upper bits.
// - Core 1 limits use separate read/write codes; core 2 shares codes.
// - Rate read at one code, written at another.
// - One-shot code starts a conversion only in standby, touches no register.
// - One-shot during a running conversion is ignored.
// - One-shot in standby does one conversion, then standby again.
// - Command pointer resets to reserved code; receive reads invalid.
// - Temperatures and limits are eight bits, sign zero, 0 to 127.
// - Readings above 127 saturate at 127.
// - Reading at/above high or at/below low limit sets alarm.
// - Alarms stick until status read, unless condition persists.
// - Status 1: busy bit 7, core 1 high/low/open bits 4,3,2.
// - Status 2: core 2 high/low/open bits 4,3,2; bit 0 mirrors alert.
// - Alert enabled and threshold crossed drives alert low.
// - Config bit 7 masks alert; writing it never releases alert.
// - Config bit 6 set halts now into standby; clear resumes auto.
// - Rate code 0..9 doubles 1/16 to 32 per second; 10 continuous.
// - Rate bit 7 set disables averaging.
// - Read-only revision byte at last code; low nibble may vary.
// - Receive byte returns register of latest read-byte command.
// - Alert released only by alert response read once fault ended.
`include "tsr_params.svh"
module tsr_regs
  import tsr_pkg::*;
#(
  parameter int          CONV_CYCLES  = 64,
  parameter int          FASTEST_CNT  = `TSR_FASTEST_US * `TSR_CLK_MHZ,
  parameter logic [7:0]  REVISION     = 8'h5A,
  parameter logic [1:0]  AVG_SAMPLES  = 2'h3
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        txn_valid,
  input  wire logic [1:0]  txn_kind,
  input  wire logic [7:0]  txn_cmd,
  input  wire logic [7:0]  txn_wdata,
  input  wire logic        ara_read,
  input  wire logic [6:0]  own_address,
  input  wire logic [8:0]  core1_sample,
  input  wire logic [8:0]  core2_sample,
  input  wire logic        core1_open_fault,
  input  wire logic        core2_open_fault,
  output logic             rdata_valid,
  output logic [7:0]       rdata,
  output logic             alert_out_n,
  output logic             busy,
  output logic             averaging_on
);
  // Revision value is arbitrary; only the upper nibble is meaningful

  ////////////////////////////////////////////////////////////////////////////
  // Host-written registers
  logic [7:0]       cfg_reg;
  logic [7:0]       rate_reg;
  logic [7:0]       hi1_reg;
  logic [7:0]       lo1_reg;
  logic [7:0]       hi2_reg;
  logic [7:0]       lo2_reg;
  logic [7:0]       ofs1_reg;
  logic [7:0]       ofs2_reg;
  logic [7:0]       ptr_reg;
  logic             wr_txn;
  logic             rd_txn;
  logic             send_txn;
  logic             recv_txn;

  assign wr_txn   = txn_valid && (txn_kind == TSR_TXN_WRITE);
  assign rd_txn   = txn_valid && (txn_kind == TSR_TXN_READ);
  assign send_txn = txn_valid && (txn_kind == TSR_TXN_SEND);
  assign recv_txn = txn_valid && (txn_kind == TSR_TXN_RECV);

  // Write decode; read-only codes ignore writes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg_reg  <= `TSR_RST_CFG;
      rate_reg <= `TSR_RST_RATE;
      hi1_reg  <= `TSR_RST_HI;
      lo1_reg  <= `TSR_RST_LO;
      hi2_reg  <= `TSR_RST_HI;
      lo2_reg  <= `TSR_RST_LO;
      ofs1_reg <= `TSR_RST_ZERO;
      ofs2_reg <= `TSR_RST_ZERO;
    end else if (wr_txn) begin
      case (txn_cmd)
        `TSR_CMD_CFG_WR:  cfg_reg  <= txn_wdata;
        `TSR_CMD_RATE_WR: rate_reg <= txn_wdata;
        `TSR_CMD_HI1_WR:  hi1_reg  <= txn_wdata;
        `TSR_CMD_LO1_WR:  lo1_reg  <= txn_wdata;
        `TSR_CMD_HI2:     hi2_reg  <= txn_wdata;
        `TSR_CMD_LO2:     lo2_reg  <= txn_wdata;
        `TSR_CMD_OFS1:    ofs1_reg <= txn_wdata;
        `TSR_CMD_OFS2:    ofs2_reg <= txn_wdata;
        default:          cfg_reg  <= cfg_reg;
      endcase
    end
  end

  // Pointer follows the latest read-byte command only
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ptr_reg <= `TSR_CMD_RSVD;
    end else if (rd_txn) begin
      ptr_reg <= txn_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  tsr_conv_state_t  state_reg;
  logic [31:0]      period_cnt_reg;
  logic [15:0]      conv_cnt_reg;
  logic             standby;
  logic             oneshot_hit;
  logic             tick;
  logic [31:0]      period_len;
  logic             conv_done;

  assign standby     = cfg_reg[`TSR_CFG_STBY_BIT];
  assign oneshot_hit = send_txn && (txn_cmd == `TSR_CMD_ONESHOT);
  assign conv_done   = (state_reg == TSR_CONV) && (conv_cnt_reg == 16'h0000);

  // Period doubles per step below the fastest code; reserved codes act continuous
  always_comb begin
    if (rate_reg[3:0] > `TSR_RATE_MAX) begin
      period_len = 32'h0000_0000;
    end else begin
      period_len = 32'(FASTEST_CNT) << (`TSR_RATE_MAX - rate_reg[3:0]);
    end
  end
  // Count ends one short so the period is exactly period_len cycles
  assign tick = ((period_cnt_reg + 32'h0000_0001) >= period_len);

  // Auto-convert period counter, idle in standby
  always_ff @(posedge core_clk) begin
    if (!rst_b || standby || tick) begin
      period_cnt_reg <= 32'h0000_0000;
    end else begin
      period_cnt_reg <= period_cnt_reg + 32'h0000_0001;
    end
  end

  // Standby aborts at once; one-shot only from idle in standby
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_reg    <= TSR_IDLE;
      conv_cnt_reg <= 16'h0000;
    end else if (wr_txn && txn_cmd == `TSR_CMD_CFG_WR && txn_wdata[`TSR_CFG_STBY_BIT]
                 && state_reg == TSR_CONV) begin
      state_reg    <= TSR_IDLE;
    end else begin
      case (state_reg)
        TSR_IDLE: begin
          if ((standby && oneshot_hit) || (!standby && tick)) begin
            state_reg    <= TSR_CONV;
            conv_cnt_reg <= 16'(CONV_CYCLES - 1);
          end
        end
        TSR_CONV: begin
          // One-shot here is simply not looked at
          if (conv_cnt_reg == 16'h0000) begin
            state_reg <= TSR_DONE;
          end else begin
            conv_cnt_reg <= conv_cnt_reg - 16'h0001;
          end
        end
        TSR_DONE: state_reg <= TSR_IDLE;
        default:  state_reg <= TSR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temperatures, alarms and alert
  logic [7:0]       t1_reg;
  logic [7:0]       t2_reg;
  logic [7:0]       t1_next;
  logic [7:0]       t2_next;
  logic [2:0]       al1_reg;
  logic [2:0]       al2_reg;
  logic [2:0]       cond1;
  logic [2:0]       cond2;
  logic             alert_reg;
  logic             fault_now;
  logic             stat1_rd;
  logic             stat2_rd;

  // Clamp sample to 0..127; a sign-set sample reads as zero
  function automatic logic [7:0] tsr_sat(input logic [8:0] s);
    if (s[8]) begin
      return 8'h00;
    end else if (s[7]) begin
      return `TSR_TEMP_MAX;
    end else begin
      return {1'b0, s[6:0]};
    end
  endfunction

  assign t1_next = tsr_sat(core1_sample);
  assign t2_next = tsr_sat(core2_sample);

  // Limit compare against stored values, open fault passed through
  assign cond1 = {t1_reg >= hi1_reg, t1_reg <= lo1_reg, core1_open_fault};
  assign cond2 = {t2_reg >= hi2_reg, t2_reg <= lo2_reg, core2_open_fault};
  assign fault_now = (|cond1) || (|cond2);

  assign stat1_rd = (rd_txn && txn_cmd == `TSR_CMD_STAT1)
                 || (recv_txn && ptr_reg == `TSR_CMD_STAT1);
  assign stat2_rd = (rd_txn && txn_cmd == `TSR_CMD_STAT2)
                 || (recv_txn && ptr_reg == `TSR_CMD_STAT2);

  // Value registers load only at conversion end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      t1_reg <= `TSR_RST_ZERO;
      t2_reg <= `TSR_RST_ZERO;
    end else if (conv_done) begin
      t1_reg <= t1_next;
      t2_reg <= t2_next;
    end
  end

  // Sticky alarms; a fresh condition beats the read clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      al1_reg <= 3'h0;
      al2_reg <= 3'h0;
    end else begin
      al1_reg <= (stat1_rd ? 3'h0 : al1_reg) | cond1;
      al2_reg <= (stat2_rd ? 3'h0 : al2_reg) | cond2;
    end
  end

  // Alert latches on fault when unmasked; only an ARA read releases it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      alert_reg <= 1'b0;
    end else if (fault_now && !cfg_reg[`TSR_CFG_MASK_BIT]) begin
      alert_reg <= 1'b1;
    end else if (ara_read && !cfg_reg[`TSR_CFG_MASK_BIT] && !fault_now) begin
      alert_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; write-only and reserved codes answer zero
  logic [7:0]       stat1_val;
  logic [7:0]       stat2_val;
  logic [7:0]       sel_cmd;
  logic [7:0]       rd_mux;
  logic             ara_answer;

  assign stat1_val = {busy, 2'b00, al1_reg, 2'b00};
  assign stat2_val = {3'b000, al2_reg, 1'b0, !alert_out_n};
  assign sel_cmd   = rd_txn ? txn_cmd : ptr_reg;
  // Masked sensors stay silent on the alert response address
  assign ara_answer = ara_read && alert_reg && !cfg_reg[`TSR_CFG_MASK_BIT];

  always_comb begin
    case (sel_cmd)
      `TSR_CMD_T1:      rd_mux = t1_reg;
      `TSR_CMD_STAT1:   rd_mux = stat1_val;
      `TSR_CMD_CFG_RD:  rd_mux = cfg_reg;
      `TSR_CMD_RATE_RD: rd_mux = rate_reg;
      `TSR_CMD_HI1_RD:  rd_mux = hi1_reg;
      `TSR_CMD_LO1_RD:  rd_mux = lo1_reg;
      `TSR_CMD_OFS1:    rd_mux = ofs1_reg;
      `TSR_CMD_STAT2:   rd_mux = stat2_val;
      `TSR_CMD_T2:      rd_mux = t2_reg;
      `TSR_CMD_HI2:     rd_mux = hi2_reg;
      `TSR_CMD_LO2:     rd_mux = lo2_reg;
      `TSR_CMD_OFS2:    rd_mux = ofs2_reg;
      `TSR_CMD_REV:     rd_mux = REVISION;
      default:          rd_mux = 8'h00;
    endcase
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_valid <= 1'b0;
      rdata       <= 8'h00;
    end else if (ara_answer) begin
      rdata_valid <= 1'b1;
      rdata       <= {own_address, 1'b0};
    end else begin
      rdata_valid <= rd_txn || recv_txn;
      rdata       <= rd_mux;
    end
  end

  // Pin and status outputs from flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      alert_out_n  <= 1'b1;
      busy         <= 1'b0;
      averaging_on <= 1'b1;
    end else begin
      alert_out_n  <= !alert_reg;
      busy         <= (state_reg == TSR_CONV);
      averaging_on <= !rate_reg[`TSR_RATE_AVG_BIT] && (AVG_SAMPLES != 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_oneshot_idle;
    standby && oneshot_hit && state_reg == TSR_IDLE;
  endsequence

  chk_oneshot_starts: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_oneshot_idle |=> state_reg == TSR_CONV)
    else $error("one-shot did not start conversion");
  chk_oneshot_ignored: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_reg == TSR_CONV && oneshot_hit && conv_cnt_reg != 16'h0000)
      |=> state_reg == TSR_CONV && conv_cnt_reg == $past(conv_cnt_reg) - 16'h0001)
    else $error("one-shot disturbed running conversion");
  chk_alarm_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
    (al1_reg[2] && !stat1_rd) |=> al1_reg[2])
    else $error("alarm lost without status read");
  chk_limit_alarm: assert property (@(posedge core_clk) disable iff (!rst_b)
    (t2_reg <= lo2_reg) |=> al2_reg[1])
    else $error("low alarm not set");
  chk_alert_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
    (fault_now && !cfg_reg[7]) |=> ##1 !alert_out_n)
    else $error("alert not driven");
  chk_alert_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    (alert_reg && !ara_read) |=> alert_reg)
    else $error("alert released without response read");
  chk_ara_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
    ara_answer |=> rdata[7:1] == $past(own_address) && rdata_valid)
    else $error("wrong alert response address");
  chk_temp_range: assert property (@(posedge core_clk) disable iff (!rst_b)
    conv_done |=> !t1_reg[7] && !t2_reg[7])
    else $error("temperature sign bit set");

  sequence s_standby_abort;
    wr_txn && txn_cmd == `TSR_CMD_CFG_WR && txn_wdata[`TSR_CFG_STBY_BIT] && state_reg == TSR_CONV;
  endsequence

  chk_standby_abort: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_standby_abort |=> state_reg == TSR_IDLE)
    else $error("standby write did not halt conversion");
  chk_ptr_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
    rd_txn |=> ptr_reg == $past(txn_cmd))
    else $error("pointer did not follow read command");
  chk_read_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rd_txn || recv_txn) |=> rdata_valid)
    else $error("read not answered");
  chk_rsvd_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    (recv_txn && ptr_reg == `TSR_CMD_RSVD && !ara_read) |=> rdata_valid && rdata == 8'h00)
    else $error("reserved pointer read not zero");
  chk_busy_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state_reg == TSR_CONV) |=> busy)
    else $error("busy not shown during conversion");
  chk_top_saturate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (conv_done && core1_sample[8:7] == 2'b01) |=> t1_reg == `TSR_TEMP_MAX)
    else $error("reading above range not saturated");
  chk_conv_end: assert property (@(posedge core_clk) disable iff (!rst_b)
    (conv_done && !wr_txn) |=> state_reg == TSR_DONE)
    else $error("conversion end step missed");
  chk_alarm_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    (stat1_rd && cond1 == 3'h0) |=> al1_reg == 3'h0)
    else $error("status read did not clear alarms");
  chk_avg_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
    rate_reg[`TSR_RATE_AVG_BIT] |=> !averaging_on)
    else $error("averaging not disabled");
  chk_mask_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ara_read && cfg_reg[`TSR_CFG_MASK_BIT] && !txn_valid) |=> !rdata_valid)
    else $error("masked sensor answered alert response");
endmodule

// ### test/tb_smbus_thermal_sensor_regs.sv
// Self-checking bench for the thermal sensor register block
`include "tsr_params.svh"
`define TB_CHK(w, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %h got %h", w, e, g); end end
module tb_smbus_thermal_sensor_regs
  import tsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int         CONV = 8;
  localparam logic [7:0] REV  = 8'h3C; // Arbitrary value
  logic        core_clk = 1'b0, rst_b = 1'b0, busy_q = 1'b0, open1 = 1'b0, open2 = 1'b0;
  logic        txn_valid, ara_read, rdata_valid, alert_out_n, busy, averaging_on, ok;
  logic [1:0]  txn_kind;
  logic [7:0]  txn_cmd, txn_wdata, rdata, v, h, rt, e;
  logic [6:0]  own_address = 7'h4C;
  logic [8:0]  s1 = 9'h000, s2 = 9'h000;
  logic [31:0] seed = 32'h5291, r;
  int          bad_count = 0, compares = 0, rises = 0, hi_len = 0, cyc = 0;
  ////////////////////////////////
  tsr_regs #(.CONV_CYCLES(CONV), .FASTEST_CNT(40), .REVISION(REV), .AVG_SAMPLES(2'h3))
  tsr_regs_inst (.core_clk(core_clk), .rst_b(rst_b), .txn_valid(txn_valid),
    .txn_kind(txn_kind), .txn_cmd(txn_cmd), .txn_wdata(txn_wdata), .ara_read(ara_read),
    .own_address(own_address), .core1_sample(s1), .core2_sample(s2),
    .core1_open_fault(open1), .core2_open_fault(open2), .rdata_valid(rdata_valid),
    .rdata(rdata), .alert_out_n(alert_out_n), .busy(busy), .averaging_on(averaging_on));
  tsr_host tsr_host_inst (.core_clk(core_clk), .rdata_valid(rdata_valid), .rdata(rdata),
    .txn_valid(txn_valid), .txn_kind(txn_kind), .txn_cmd(txn_cmd),
    .txn_wdata(txn_wdata), .ara_read(ara_read));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // Busy starts and length; also the hang limit, far above the expected run
  always @(posedge core_clk) begin
    busy_q <= busy;
    rises <= rises + int'(busy && !busy_q);
    hi_len <= hi_len + int'(busy);
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Positive raw values only; sign handling of negatives is left open
  function automatic logic [7:0] sat(input logic [8:0] s);
    return (s > 9'h07F) ? 8'h7F : s[7:0];
  endfunction
  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reads and receives must be answered
  task automatic op(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d = 8'h00);
    tsr_host_inst.xfer(k, c, d, 1'b0, ok, v);
    if (k[0]) `TB_CHK("answer strobe", 1'b1, ok)
  endtask
  task automatic wbusy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `TB_CHK("busy level", lvl, busy)
  endtask
  // One single conversion, with a second trigger thrown in while busy
  task automatic conv();
    rises = 0;
    hi_len = 0;
    op(TSR_TXN_SEND, `TSR_CMD_ONESHOT);
    wbusy(1'b1);
    op(TSR_TXN_SEND, `TSR_CMD_ONESHOT);
    op(TSR_TXN_READ, `TSR_CMD_STAT1);
    `TB_CHK("busy bit", 1'b1, v[7])
    wbusy(1'b0);
    repeat (40) @(posedge core_clk);
    #1;
    `TB_CHK("one conversion", 1, rises)
    `TB_CHK("busy length", CONV, hi_len)
  endtask
  ////////////////////////////////
  initial begin
    logic [7:0] rc [10], rv [10];
    rc = '{8'h01, 8'h03, 8'h04, 8'h07, 8'h08, 8'h11, 8'h30, 8'h32, 8'h33, 8'h34};
    rv = '{8'h00, 8'h00, 8'h07, 8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (12) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    r = rnd();
    own_address = r[6:0];
    `TB_CHK("averaging after reset", 1'b1, averaging_on)
    op(TSR_TXN_RECV, 8'h00);
    `TB_CHK("pointer after reset", 8'h00, v)
    for (int i = 0; i < 10; i++) begin
      op(TSR_TXN_READ, rc[i]);
      `TB_CHK("reset value", rv[i], v)
    end
    // Zero readings sit exactly on the zero low limits
    op(TSR_TXN_READ, `TSR_CMD_STAT1);
    `TB_CHK("low alarm at equal", 8'h08, v & 8'h1C)
    op(TSR_TXN_READ, `TSR_CMD_STAT2);
    `TB_CHK("core2 low and alert bit", 8'h09, v & 8'h1D)
    `TB_CHK("alert pin low", 1'b0, alert_out_n)
    op(TSR_TXN_WRITE, `TSR_CMD_CFG_WR, 8'h40);
    wbusy(1'b0);
    op(TSR_TXN_WRITE, `TSR_CMD_LO1_WR, 8'h05);
    op(TSR_TXN_WRITE, `TSR_CMD_LO2, 8'h05);
    op(TSR_TXN_WRITE, `TSR_CMD_HI2, 8'h60);
    s1 = 9'h030;
    s2 = 9'h030;
    conv();
    for (int i = 0; i < 4; i++) begin
      op(TSR_TXN_READ, i[1] ? `TSR_CMD_STAT2 : `TSR_CMD_STAT1);
      `TB_CHK("sticky then cleared", i[0] ? 8'h00 : 8'h08, v & 8'h1C)
    end
    `TB_CHK("alert kept by reads", 1'b0, alert_out_n)
    op(TSR_TXN_WRITE, `TSR_CMD_CFG_WR, 8'hC0);
    `TB_CHK("alert kept by mask", 1'b0, alert_out_n)
    tsr_host_inst.xfer(2'h0, 8'h00, 8'h00, 1'b1, ok, v);
    `TB_CHK("masked alert response", 1'b0, ok)
    op(TSR_TXN_WRITE, `TSR_CMD_CFG_WR, 8'h40);
    tsr_host_inst.xfer(2'h0, 8'h00, 8'h00, 1'b1, ok, v);
    `TB_CHK("alert response strobe", 1'b1, ok)
    `TB_CHK("alert response address", own_address, v[7:1])
    repeat (2) @(posedge core_clk);
    #1;
    `TB_CHK("alert released", 1'b1, alert_out_n)
    op(TSR_TXN_READ, `TSR_CMD_STAT2);
    `TB_CHK("alert bit cleared", 1'b0, v[0])
    op(TSR_TXN_READ, `TSR_CMD_REV);
    `TB_CHK("revision upper nibble", REV[7:4], v[7:4])
    // Random limits, rates and readings; first three straddle the top of range
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      h = {1'b0, r[6:0]};
      rt = {r[26], 3'b000, (r[30:27] > 4'h9) ? 4'h9 : r[30:27]};
      op(TSR_TXN_WRITE, `TSR_CMD_HI1_WR, h);
      op(TSR_TXN_WRITE, `TSR_CMD_HI1_RD, ~h);
      op(TSR_TXN_READ, `TSR_CMD_HI1_RD);
      `TB_CHK("core1 high limit", h, v)
      op(TSR_TXN_RECV, 8'h00);
      `TB_CHK("repeat read", h, v)
      op(TSR_TXN_WRITE, `TSR_CMD_RATE_WR, rt);
      op(TSR_TXN_READ, `TSR_CMD_RATE_RD);
      `TB_CHK("rate readback", rt, v)
      `TB_CHK("averaging pin", ~rt[7], averaging_on)
      s1 = (i < 3) ? 9'h07F + 9'(i) : {1'b0, r[15:8]};
      s2 = {1'b0, r[23:16]};
      open1 = r[24];
      open2 = r[25];
      conv();
      op(TSR_TXN_READ, `TSR_CMD_T1);
      `TB_CHK("core1 reading", sat(s1), v)
      op(TSR_TXN_READ, `TSR_CMD_T2);
      `TB_CHK("core2 reading", sat(s2), v)
      e = {3'b000, sat(s1) >= h, sat(s1) <= 8'h05, open1, 2'b00};
      op(TSR_TXN_READ, `TSR_CMD_STAT1);
      op(TSR_TXN_READ, `TSR_CMD_STAT1);
      `TB_CHK("core1 flags", e, v & 8'h1C)
    end
    open1 = 1'b0;
    open2 = 1'b0;
    // Automatic mode at the two fastest timed codes
    for (int i = 0; i < 2; i++) begin
      op(TSR_TXN_WRITE, `TSR_CMD_RATE_WR, i ? 8'h08 : 8'h09);
      op(TSR_TXN_WRITE, `TSR_CMD_CFG_WR, 8'h00);
      rises = 0;
      repeat (400) @(posedge core_clk);
      #1;
      `TB_CHK("auto rate", 1'b1, rises >= (10 >> i) - 1 && rises <= (10 >> i) + 1)
    end
    // Catch a fresh conversion so the standby write lands mid-conversion
    wbusy(1'b0);
    wbusy(1'b1);
    op(TSR_TXN_WRITE, `TSR_CMD_CFG_WR, 8'h40);
    @(posedge core_clk);
    #1;
    `TB_CHK("standby halts at once", 1'b0, busy)
    repeat (12) @(posedge core_clk);
    #1;
    rises = 0;
    repeat (200) @(posedge core_clk);
    #1;
    `TB_CHK("standby quiet", 0, rises)
    report_and_stop();
  end
endmodule

// ### test/tsr_host.sv
// SMBus host controller model issuing decoded transactions
`include "tsr_params.svh"
module tsr_host
  import tsr_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rdata_valid,
  input  wire logic [7:0] rdata,
  output logic            txn_valid = 1'b0,
  output logic [1:0]      txn_kind = 2'h0,
  output logic [7:0]      txn_cmd = 8'hA5,
  output logic [7:0]      txn_wdata = 8'h5A,
  output logic            ara_read = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] cfg_shadow = 8'h00;
  ////////////////////////////////
  // One request per call; freed lines carry the inverse byte so stale data never matches
  task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d,
                      input logic a, output logic ok, output logic [7:0] rd);
    logic w;
    w = (k == TSR_TXN_WRITE) && !a;
    ok = 1'b0;
    rd = 8'h00;
    if (w && c == `TSR_CMD_CFG_WR) d = d & 8'hD0;
    if (w && c == `TSR_CMD_RATE_WR) d = d & 8'hCF;
    if (w && c == `TSR_CMD_CFG_WR) cfg_shadow = d;
    // Single conversions only from standby
    if (k == TSR_TXN_SEND && c == `TSR_CMD_ONESHOT && !cfg_shadow[6]) return;
    @(posedge core_clk);
    #1;
    {txn_valid, ara_read, txn_kind, txn_cmd, txn_wdata} = {!a, a, k, c, d};
    @(posedge core_clk);
    #1;
    {ok, rd} = {rdata_valid, rdata};
    {txn_valid, ara_read, txn_cmd, txn_wdata} = {2'b00, ~c, ~d};
  endtask
endmodule
